// File: design/attenuator_link_if.sv
/*
  Three-wire link between the host end and the attenuator end, plus the
  chain output coming back.
  Assumes the bench joins both modports; all wires are one-way.
*/
`timescale 1ns/100ps
interface attenuator_link_if;
  logic linkClk;
  logic frameSelN;
  logic serialIn;
  logic chainOut;

  modport device (
    input  linkClk,
    input  frameSelN,
    input  serialIn,
    output chainOut
  );

  modport host (
    output linkClk,
    output frameSelN,
    output serialIn,
    input  chainOut
  );
endinterface : attenuator_link_if

// File: design/serial_attenuator_control.sv
/*
  Attenuator end: samples the link pins, shifts 16-bit words, passes
  displaced bits down the chain and applies latched words to channels.
  Assumes the link pins are asynchronous to sys_clk and that a link
  half period spans at least four sys_clk cycles.
*/
//
// Function
// - sample serial data on link clock rise
// - shift only while frame select low
// - displaced bits leave on chain output
// - host raises frame after all bits
// - frame low 150 ns before first rise
// - frame stays low for whole word
// - word is 8-bit address, 8-bit attenuation
// - MSB first, address field before attenuation
// - all channels muted at power-up
// - code 0x4F or above mutes channel
// - valid address applies latched code
// - channel codes 0x00, 0x01, 0x02
// - unaddressed channels keep their settings
// - chain of n needs 16n bits; the registered chain output adds one bit per hop, so 17n-1 here
`timescale 1ns/100ps
module serial_attenuator_control
  import serial_attenuator_pkg::*;
(
  input  wire logic                             sys_clk,
  input  wire logic                             reset,
  attenuator_link_if.device                     link,
  output logic [NUM_CHAN-1:0]                   chanMuted_q,
  output logic [NUM_CHAN-1:0][FIELD_BITS-1:0]   chanCode_q,
  output logic [NUM_CHAN-1:0][FIELD_BITS-1:0]   chanLevel_q,
  output logic                                  wordLatched_q,
  output logic                                  badAddr_q
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // channel index of an address, NUM_CHAN when not recognised
  function automatic int chanIndex(input logic [FIELD_BITS-1:0] addr);
    int idx;
    idx = NUM_CHAN;
    if (addr == CHAN_ONE_CODE) begin
      idx = 0;
    end else if (addr == CHAN_TWO_CODE) begin
      idx = 1;
    end else if (addr == CHAN_THREE_CODE) begin
      idx = 2;
    end
    return idx;
  endfunction : chanIndex

  // level in half-dB units for a code
  function automatic logic [FIELD_BITS-1:0] halfDb(
    input logic [FIELD_BITS-1:0] code
  );
    logic [FIELD_BITS-1:0] lvl;
    lvl = MUTE_LEVEL;
    if (code < FINE_END) begin
      lvl = code;
    end else if (code < MEDIUM_END) begin
      lvl = FIELD_BITS'(MEDIUM_BASE + ((code - FINE_END) << 1));
    end else if (code < MUTE_MIN) begin
      lvl = FIELD_BITS'(COARSE_BASE + ((code - MEDIUM_END) << 2));
    end
    return lvl;
  endfunction : halfDb

  // ----------------------------------------------------------------
  // pin synchronisers and agreement filter
  // ----------------------------------------------------------------
  logic [2:0] pinsRaw;
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [2:0] sync3_q;
  logic [2:0] pins_q;
  logic [2:0] pins_d;
  logic [2:0] differ;

  assign pinsRaw[PIN_CLK]   = link.linkClk;
  assign pinsRaw[PIN_FRAME] = link.frameSelN;
  assign pinsRaw[PIN_DATA]  = link.serialIn;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sync1_q <= PINS_IDLE;
      sync2_q <= PINS_IDLE;
      sync3_q <= PINS_IDLE;
    end else begin
      sync1_q <= pinsRaw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // a pin changes only once the two later stages agree; a one-cycle
  // glitch on the cable never reaches the shift logic
  assign differ = sync2_q ^ sync3_q;
  assign pins_d = (sync3_q & ~differ) | (pins_q & differ);
  // limitation: a link level must stand two sys_clk or more, or the
  // filter swallows it and the bit is lost

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pins_q <= PINS_IDLE;
    end else begin
      pins_q <= pins_d;
    end
  end

  // ----------------------------------------------------------------
  // edge detection
  // ----------------------------------------------------------------
  logic clkRise;
  logic frameRise;
  logic shiftEn;

  assign clkRise   = pins_d[PIN_CLK] & ~pins_q[PIN_CLK];
  assign frameRise = pins_d[PIN_FRAME] & ~pins_q[PIN_FRAME];
  // data is taken from the same filtered snapshot as the clock edge
  assign shiftEn   = clkRise & ~pins_d[PIN_FRAME];
  // a shift and a latch never share a cycle: one needs the filtered
  // frame low, the other its rise

  // ----------------------------------------------------------------
  // shift register and chain output
  // ----------------------------------------------------------------
  logic [WORD_BITS-1:0] shift_q;
  logic                 chainOut_q;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      shift_q <= '0;
    end else if (shiftEn) begin
      // first bit in ends at the top: MSB-first, address first
      shift_q <= {shift_q[WORD_BITS-2:0], pins_d[PIN_DATA]};
    end
  end

  // the bit pushed out of the top goes downstream; it moves only on a
  // shift so it is settled well before the next rise
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      chainOut_q <= 1'b0;
    end else if (shiftEn) begin
      chainOut_q <= shift_q[WORD_BITS-1];
    end
  end

  assign link.chainOut = chainOut_q;

  // ----------------------------------------------------------------
  // latch and decode
  // ----------------------------------------------------------------
  logic [FIELD_BITS-1:0] latchAddr;
  logic [FIELD_BITS-1:0] latchCode;
  int                    target;

  assign latchAddr = shift_q[ADDR_MSB:ADDR_LSB];
  assign latchCode = shift_q[ATTN_MSB:0];
  assign target    = chanIndex(latchAddr);
  // the shift register doubles as the latch: it is read only on the
  // filtered frame rise, and no shift can come in that cycle

  // ----------------------------------------------------------------
  // channel settings
  // ----------------------------------------------------------------
  // a mute code is kept as sent so that the host can read back what
  // it asked for; the level output already shows the mute level
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      // power-up places every channel into mute
      chanMuted_q <= '1;
      for (int i = 0; i < NUM_CHAN; i++) begin
        chanCode_q[i]  <= MUTE_CODE;
        chanLevel_q[i] <= MUTE_LEVEL;
      end
    end else if (frameRise) begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        // only the addressed channel moves
        if (target == i) begin
          chanCode_q[i]  <= latchCode;
          chanLevel_q[i] <= halfDb(latchCode);
          chanMuted_q[i] <= (latchCode >= MUTE_MIN);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // status pulses
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wordLatched_q <= 1'b0;
      badAddr_q     <= 1'b0;
    end else begin
      wordLatched_q <= frameRise;
      badAddr_q     <= frameRise & (target == NUM_CHAN);
    end
  end

endmodule : serial_attenuator_control

// File: design/serial_attenuator_host.sv
/*
  Host end: makes the link clock by dividing sys_clk, frames one 16-bit
  word, and captures the 16 bits that the chain pushes back.
  Assumes a single attenuator on the link and a request only when idle.
*/
`timescale 1ns/100ps
module serial_attenuator_host
  import serial_attenuator_pkg::*;
(
  input  wire logic                   sys_clk,
  input  wire logic                   reset,
  attenuator_link_if.host             link,
  input  wire logic                   sendReq,
  input  wire logic [FIELD_BITS-1:0]  sendChan,
  input  wire logic [FIELD_BITS-1:0]  sendCode,
  output logic                        busy_q,
  output logic                        done_q,
  output logic [WORD_BITS-1:0]        chainWord_q
);

  typedef enum logic [2:0] {
    IDLE, SETUP, LOW, HIGH, TAIL, RAISE
  } host_state_type;

  host_state_type       state_q;
  logic [CNT_BITS-1:0]  cnt_q;
  logic [4:0]           bit_q;
  logic [WORD_BITS-1:0] word_q;
  logic                 linkClk_q;
  logic                 frameN_q;
  logic                 data_q;
  logic                 cnt_end;

  // ----------------------------------------------------------------
  // chain input synchroniser, filtered like the device pins
  // ----------------------------------------------------------------
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic chainIn_q;
  logic chainNow;

  // the filtered value counts as soon as stages two and three agree;
  // waiting for chainIn_q would hand the capture the previous bit
  assign chainNow = (s2_q == s3_q) ? s3_q : chainIn_q;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s1_q      <= 1'b0;
      s2_q      <= 1'b0;
      s3_q      <= 1'b0;
      chainIn_q <= 1'b0;
    end else begin
      s1_q <= link.chainOut;
      s2_q <= s1_q;
      s3_q <= s2_q;
      chainIn_q <= chainNow;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  assign cnt_end = (state_q == SETUP) ? (cnt_q == SETUP_LAST)
                                      : (cnt_q == HALF_LAST);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_q   <= IDLE;
      cnt_q     <= '0;
      bit_q     <= '0;
      word_q    <= '0;
      linkClk_q <= 1'b0;
      frameN_q  <= 1'b1;
      data_q    <= 1'b0;
      busy_q    <= 1'b0;
      done_q    <= 1'b0;
    end else begin
      done_q <= 1'b0;
      cnt_q  <= cnt_end ? '0 : CNT_BITS'(cnt_q + 1'b1);
      case (state_q)
        IDLE: begin
          cnt_q <= '0;
          if (sendReq) begin
            word_q   <= {sendChan, sendCode};
            frameN_q <= 1'b0;
            busy_q   <= 1'b1;
            bit_q    <= '0;
            state_q  <= SETUP;
          end
        end
        SETUP: begin
          // frame low well ahead of the first rise
          if (cnt_end) begin
            data_q  <= word_q[WORD_BITS-1];
            word_q  <= {word_q[WORD_BITS-2:0], 1'b0};
            state_q <= LOW;
          end
        end
        LOW: begin
          if (cnt_end) begin
            linkClk_q <= 1'b1;
            state_q   <= HIGH;
          end
        end
        HIGH: begin
          if (cnt_end) begin
            linkClk_q <= 1'b0;
            if (bit_q == BIT_LAST) begin
              state_q <= TAIL;
            end else begin
              data_q  <= word_q[WORD_BITS-1];
              word_q  <= {word_q[WORD_BITS-2:0], 1'b0};
              bit_q   <= 5'(bit_q + 1'b1);
              state_q <= LOW;
            end
          end
        end
        TAIL: begin
          // frame held low over all 16 bits, raised after
          if (cnt_end) begin
            frameN_q <= 1'b1;
            state_q  <= RAISE;
          end
        end
        RAISE: begin
          if (cnt_end) begin
            busy_q  <= 1'b0;
            done_q  <= 1'b1;
            state_q <= IDLE;
          end
        end
        default: state_q <= IDLE;
      endcase
    end
  end

  // displaced bits are read at the end of each low phase after a rise,
  // long enough for the far end and our synchroniser to settle
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      chainWord_q <= '0;
    end else if (cnt_end && (state_q == TAIL ||
                 (state_q == LOW && bit_q != '0))) begin
      chainWord_q <= {chainWord_q[WORD_BITS-2:0], chainNow};
    end
  end

  assign link.linkClk   = linkClk_q;
  assign link.frameSelN = frameN_q;
  assign link.serialIn  = data_q;

endmodule : serial_attenuator_host

// File: design/serial_attenuator_pkg.sv
/*
  Shared constants for the serial attenuator link: word layout, channel
  codes, attenuation decode limits and link timing.
  Assumes both ends run on a 10 MHz system clock.
*/
package serial_attenuator_pkg;

  // ----------------------------------------------------------------
  // word layout
  // ----------------------------------------------------------------
  localparam int FIELD_BITS = 8;
  localparam int WORD_BITS  = 2 * FIELD_BITS;
  localparam int NUM_CHAN   = 3;
  localparam int ADDR_MSB   = WORD_BITS - 1;
  localparam int ADDR_LSB   = FIELD_BITS;
  localparam int ATTN_MSB   = FIELD_BITS - 1;

  localparam logic [FIELD_BITS-1:0] CHAN_ONE_CODE   = 8'h00;
  localparam logic [FIELD_BITS-1:0] CHAN_TWO_CODE   = 8'h01;
  localparam logic [FIELD_BITS-1:0] CHAN_THREE_CODE = 8'h02;

  // ----------------------------------------------------------------
  // attenuation decode, levels in half-dB units
  // ----------------------------------------------------------------
  localparam logic [FIELD_BITS-1:0] FINE_END   = 8'h20;
  localparam logic [FIELD_BITS-1:0] MEDIUM_END = 8'h40;
  localparam logic [FIELD_BITS-1:0] MUTE_MIN   = 8'h4F;
  localparam logic [FIELD_BITS-1:0] MEDIUM_BASE = 8'h20;
  localparam logic [FIELD_BITS-1:0] COARSE_BASE = 8'h60;
  localparam logic [FIELD_BITS-1:0] MUTE_LEVEL  = 8'hC8;
  localparam logic [FIELD_BITS-1:0] MUTE_CODE   = 8'hFF;

  // ----------------------------------------------------------------
  // link pins: {link clock, frame select low, serial data}
  // ----------------------------------------------------------------
  localparam int PIN_CLK   = 2;
  localparam int PIN_FRAME = 1;
  localparam int PIN_DATA  = 0;
  localparam logic [2:0] PINS_IDLE = 3'h2;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int SYS_PERIOD_NS  = 100;
  localparam int FRAME_SETUP_NS = 150;
  localparam int LINK_PERIOD_NS = 800;
  localparam int SETUP_CYCLES =
    (FRAME_SETUP_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int HALF_CYCLES = LINK_PERIOD_NS / 2 / SYS_PERIOD_NS;
  localparam int CNT_BITS = 4;
  localparam logic [CNT_BITS-1:0] SETUP_LAST =
    CNT_BITS'(SETUP_CYCLES - 1);
  localparam logic [CNT_BITS-1:0] HALF_LAST =
    CNT_BITS'(HALF_CYCLES - 1);
  localparam logic [4:0] BIT_LAST = 5'(WORD_BITS - 1);

endpackage : serial_attenuator_pkg

// File: verif/serial_attenuator_control_bench.sv
/*
  Bench: host and attenuator on one link, a second attenuator driven
  directly by the bench to clock it outside a frame.
  Assumes package and interface are compiled first.
*/
`timescale 1ns/100ps
module serial_attenuator_control_bench import serial_attenuator_pkg::*;;
  logic            sys_clk, reset, sendReq, busy, done, latchA, badA, co;
  logic [7:0]      sendChan, sendCode;
  logic [15:0]     chainWord, prevWord, bout;
  logic [2:0]      mutedA, mutedB, expMuted;
  logic [2:0][7:0] codeA, levelA, codeB, levelB, expCode, expLevel;
  logic [31:0]     seed;
  logic [7:0]      corner [8] = '{8'h00, 8'h1F, 8'h20, 8'h3F,
                                  8'h40, 8'h4E, 8'h4F, 8'hFF};
  int              err_count, check_count, latchCnt, badCnt, cycles;
  bit              havePrev;

  attenuator_link_if linkA ();
  attenuator_link_if linkB ();

  serial_attenuator_host serial_attenuator_host_inst (.sys_clk(sys_clk),
    .reset(reset), .link(linkA.host), .sendReq(sendReq),
    .sendChan(sendChan), .sendCode(sendCode), .busy_q(busy),
    .done_q(done), .chainWord_q(chainWord));
  serial_attenuator_control serial_attenuator_control_inst (
    .sys_clk(sys_clk), .reset(reset), .link(linkA.device),
    .chanMuted_q(mutedA), .chanCode_q(codeA), .chanLevel_q(levelA),
    .wordLatched_q(latchA), .badAddr_q(badA));
  serial_attenuator_control serial_attenuator_control_inst_2 (
    .sys_clk(sys_clk), .reset(reset), .link(linkB.device),
    .chanMuted_q(mutedB), .chanCode_q(codeB), .chanLevel_q(levelB),
    .wordLatched_q(), .badAddr_q());
  serial_attenuator_monitor serial_attenuator_monitor_inst (
    .sys_clk(sys_clk), .reset(reset), .linkClk(linkA.linkClk),
    .frameSelN(linkA.frameSelN), .serialIn(linkA.serialIn),
    .chainOut(linkA.chainOut));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] lvl(input logic [7:0] c);
    if (c >= 8'h4F) return 8'hC8;
    if (c < 8'h20) return c;
    if (c < 8'h40) return 8'(2 * c - 8'h20);
    return 8'(4 * c - 8'hA0);
  endfunction : lvl

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                       input string what);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s %h not %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic finish_test;
    if (err_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test

  task automatic compare_state;
    check({13'h0, mutedA}, {13'h0, expMuted}, "mute");
    for (int i = 0; i < 3; i++) begin
      check({8'h0, codeA[i]}, {8'h0, expCode[i]}, "code");
      check({8'h0, levelA[i]}, {8'h0, expLevel[i]}, "level");
    end
  endtask : compare_state

  task automatic send(input logic [7:0] ch, input logic [7:0] cd);
    int l0, b0, n;
    l0 = latchCnt;
    b0 = badCnt;
    n = 0;
    @(negedge sys_clk);
    sendReq = 1'b1;
    sendChan = ch;
    sendCode = cd;
    @(negedge sys_clk);
    sendReq = 1'b0;
    check({15'h0, busy}, 16'h1, "busy");
    while (done !== 1'b1 && n < 400) begin
      @(negedge sys_clk);
      n++;
    end
    check({15'h0, busy}, 16'h0, "busy end");
    check({15'h0, linkA.frameSelN}, 16'h1, "frame idle");
    repeat (4) @(negedge sys_clk);
    if (ch < 8'h03) begin
      expMuted[ch[1:0]] = (cd >= 8'h4F);
      expCode[ch[1:0]] = cd;
      expLevel[ch[1:0]] = lvl(cd);
    end
    check(16'(n < 400), 16'h1, "done");
    compare_state();
    check(16'(latchCnt - l0), 16'h1, "latch");
    check(16'(badCnt - b0), 16'(ch > 8'h02), "bad address");
    if (havePrev) check(chainWord, prevWord, "chain word");
    prevWord = {ch, cd};
    havePrev = 1'b1;
  endtask : send

  // a bit on the second link: low phase, sample chain, high phase
  task automatic bbit(input logic d, output logic c);
    @(negedge sys_clk);
    linkB.serialIn = d;
    linkB.linkClk = 1'b0;
    repeat (4) @(negedge sys_clk);
    c = linkB.chainOut;
    linkB.linkClk = 1'b1;
    repeat (3) @(negedge sys_clk);
  endtask : bbit

  task automatic bword(input logic [15:0] w, output logic [15:0] o);
    @(negedge sys_clk);
    linkB.frameSelN = 1'b0;
    repeat (3) @(negedge sys_clk);
    for (int i = 15; i >= 0; i--) begin
      bbit(w[i], co);
      o = {o[14:0], co};
    end
    @(negedge sys_clk);
    linkB.linkClk = 1'b0;
    repeat (4) @(negedge sys_clk);
    o = {o[14:0], linkB.chainOut};
    linkB.frameSelN = 1'b1;
    repeat (8) @(negedge sys_clk);
  endtask : bword

  // ---------------------------------------------------------------
  // clock, pulse counting, hang limit
  // ---------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    latchCnt += int'(latchA === 1'b1);
    badCnt += int'(badA === 1'b1);
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      finish_test();
    end
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {reset, sendReq, sendChan, sendCode} = {1'b1, 17'h0};
    {linkB.linkClk, linkB.frameSelN, linkB.serialIn} = PINS_IDLE;
    seed = 32'h90E411C6;
    expMuted = 3'h7;
    expCode = {3{8'hFF}};
    expLevel = {3{8'hC8}};
    repeat (9) @(negedge sys_clk);
    reset = 1'b0;
    compare_state();
    for (int i = 0; i < 8; i++) send(8'(i % 3), corner[i]);
    send(8'h03, 8'h10);
    send(8'hFF, 8'h00);
    for (int i = 0; i < 24; i++) begin
      seed = xs(seed);
      send({6'h0, seed[1:0]}, seed[15:8]);
    end
    bword(16'h023F, bout);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      bbit(seed[3], co);
    end
    bword(16'h011A, bout);
    check(bout, 16'h023F, "shifted out");
    check({13'h0, mutedB}, 16'h1, "second mute");
    check({8'h0, levelB[1]}, {8'h0, lvl(8'h1A)}, "second level");
    check({8'h0, levelB[2]}, {8'h0, lvl(8'h3F)}, "third level");
    finish_test();
  end
endmodule : serial_attenuator_control_bench

// File: verif/serial_attenuator_monitor.sv
/*
  Checker for the attenuator link: framing, clock shape and chain data.
  Assumes all four wires are driven by the two design ends.
*/
`timescale 1ns/100ps
module serial_attenuator_monitor (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic linkClk,
  input wire logic frameSelN,
  input wire logic serialIn,
  input wire logic chainOut
);
  // ---------------------------------------------------------------
  // helper logic
  // ---------------------------------------------------------------
  logic        clkPrev_q;
  logic        framePrev_q;
  logic [4:0]  riseCnt_q;
  logic [3:0]  riseAge_q;
  logic [4:0]  shiftCnt_q;
  logic [16:0] shadow_q;
  logic        clkRise;

  assign clkRise = linkClk && !clkPrev_q;

  always_ff @(posedge sys_clk) begin
    clkPrev_q   <= reset ? 1'b0 : linkClk;
    framePrev_q <= reset ? 1'b1 : frameSelN;
  end

  always_ff @(posedge sys_clk) begin
    if (reset || (framePrev_q && !frameSelN)) riseCnt_q <= 5'h0;
    else if (clkRise) riseCnt_q <= riseCnt_q + 5'h1;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) riseAge_q <= 4'hF;
    else if (clkRise) riseAge_q <= 4'h0;
    else if (riseAge_q != 4'hF) riseAge_q <= riseAge_q + 4'h1;
  end

  // a 17-bit shadow keeps the bit that the attenuator displaces last
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      shiftCnt_q <= 5'h0;
      shadow_q   <= 17'h0;
    end else if (clkRise && !frameSelN) begin
      shadow_q <= {shadow_q[15:0], serialIn};
      if (shiftCnt_q != 5'h11) shiftCnt_q <= shiftCnt_q + 5'h1;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking mclk @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  a_frame_setup: assert property ($fell(frameSelN) |-> !linkClk [*2])
    else $error("link clock rose too soon after frame start");
  a_clock_in_frame: assert property (linkClk |-> !frameSelN)
    else $error("link clock high outside a frame");
  a_bit_count: assert property (
    $rose(frameSelN) |-> riseCnt_q == 5'h10)
    else $error("frame closed without sixteen clock rises");
  a_high_hold: assert property (
    $rose(linkClk) |-> linkClk [*4] ##1 !linkClk)
    else $error("link clock high phase not four cycles");
  a_low_hold: assert property ($fell(linkClk) |-> !linkClk [*4])
    else $error("link clock low phase shorter than four cycles");
  a_data_steady: assert property (linkClk |-> $stable(serialIn))
    else $error("serial data moved while link clock high");
  a_chain_timing: assert property (
    $changed(chainOut) |-> riseAge_q inside {[1:8]})
    else $error("chain output moved away from a shift");
  a_chain_bit: assert property (
    clkRise && shiftCnt_q == 5'h11 |-> chainOut == shadow_q[16])
    else $error("chain output is not the displaced bit");
endmodule : serial_attenuator_monitor
